// ---- hw/hid_report_i2c_master_transfer.sv ----
// HID output report to I2C master transfer bridge with status report
`timescale 1ns/1ps
`include "hid_i2c_cfg.svh"

module hid_report_i2c_master_transfer
  import hid_i2c_pkg::*;
#(
  parameter int BUS_FREE_CYC =
    int'(64'(`BUS_FREE_MS) * 64'(`CLK_HZ) / 64'd1000),
  parameter int BYTE_CYC = int'(64'(`BYTE_MS) * 64'(`CLK_HZ) / 64'd1000)
) (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        out_valid,
  input  wire logic [7:0]  out_data,
  input  wire logic        out_last,
  output logic             out_ready,
  output logic             in_valid,
  output logic [7:0]       in_data,
  output logic             in_last,
  input  wire logic        in_ready,
  input  wire logic        feat_valid,
  input  wire logic [7:0]  feat_id,
  input  wire logic [15:0] feat_addr,
  input  wire logic [15:0] feat_wdata,
  output logic [15:0]      feat_rdata,
  output logic             feat_rvalid,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe
);

  xfer_state_t st_q;
  logic        scl_m_q, scl_s_q, sda_m_q, sda_s_q;
  logic        low_q;
  logic [15:0] scl_low_q, scl_high_q, rd_ptr_q, feat_rdata_q;
  logic        feat_rvalid_q;
  logic        out_ready_q, len_ok_q;
  logic [5:0]  rx_idx_q, resp_idx_q;
  logic [7:0]  id_q, flags_q, wcnt_q, rcnt_q, addr_q;
  logic [7:0]  wbuf_q [`MAX_XFER];
  logic [7:0]  rbuf_q [`MAX_XFER];
  logic [5:0]  widx_q, ridx_q, wdone_q;
  logic        addr_pend_q, rd_phase_q, rd_byte_q, is_addr_q;
  logic [8:0]  tx_q;
  logic [7:0]  rx_sh_q;
  logic [3:0]  bit_q;
  logic [15:0] tmr_q;
  logic [31:0] wd_q;
  logic        rerr_q, nack_q, arb_q, tmo_q;
  logic        scl_oe_q, sda_oe_q;
  logic        in_valid_q, in_last_q, skid_v_q, skid_last_q;
  logic [7:0]  in_data_q, skid_q;
  logic        push, push_last, tmr_done, bad_req;
  logic [7:0]  resp_byte;

  // Two-stage synchronisers on the open-drain pins
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
    end else begin
      scl_m_q <= scl_in;
      scl_s_q <= scl_m_q;
      sda_m_q <= sda_in;
      sda_s_q <= sda_m_q;
    end
  end

  // Pins only ever pull low
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) low_q <= 1'b0;
    else low_q <= 1'b0;
  end

  // Feature reports on the control side
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      scl_low_q     <= `SCL_LOW_RST;
      scl_high_q    <= `SCL_HIGH_RST;
      rd_ptr_q      <= 16'h0000;
      feat_rdata_q  <= 16'h0000;
      feat_rvalid_q <= 1'b0;
    end else begin
      feat_rvalid_q <= 1'b0;
      if (feat_valid) begin
        case (feat_id)
          `FEAT_REG_WRITE: begin
            if (feat_addr == `REG_SCL_LOW) scl_low_q <= feat_wdata;
            if (feat_addr == `REG_SCL_HIGH) scl_high_q <= feat_wdata;
          end
          `FEAT_READ_PTR: rd_ptr_q <= feat_addr;
          `FEAT_READBACK: begin
            feat_rvalid_q <= 1'b1;
            case (rd_ptr_q)
              `REG_SCL_LOW:  feat_rdata_q <= scl_low_q;
              `REG_SCL_HIGH: feat_rdata_q <= scl_high_q;
              `REG_STATUS:   feat_rdata_q <= {11'h000, out_ready_q, st_q};
              default:       feat_rdata_q <= 16'h0000;
            endcase
          end
          default: ;
        endcase
      end
    end
  end

  // Answer report bytes, generated straight from transfer state
  always_comb begin
    resp_byte = 8'h00;
    case (resp_idx_q)
      6'd0: resp_byte = {flags_q[7:4], tmo_q, arb_q, nack_q, rerr_q};
      6'd1: resp_byte = {2'b00, wdone_q};
      6'd2: resp_byte = {2'b00, ridx_q};
      6'd3: resp_byte = 8'h00;
      default: begin
        if ((resp_idx_q - 6'(`IN_OFS_DATA)) < ridx_q)
          resp_byte = rbuf_q[5'(resp_idx_q - 6'(`IN_OFS_DATA))];
      end
    endcase
  end

  assign push      = (st_q == S_RESP) && !skid_v_q;
  assign push_last = resp_idx_q == 6'(`IN_REPORT_LEN - 1);
  assign tmr_done  = tmr_q <= 16'd1;
  assign bad_req   = !len_ok_q || id_q != `OUT_REPORT_ID ||
                     wcnt_q > 8'(`MAX_XFER) || rcnt_q > 8'(`MAX_XFER);

  // Output stage plus skid entry, so a stalled receiver loses nothing
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      in_valid_q  <= 1'b0;
      in_data_q   <= 8'h00;
      in_last_q   <= 1'b0;
      skid_v_q    <= 1'b0;
      skid_q      <= 8'h00;
      skid_last_q <= 1'b0;
    end else if (!in_valid_q || in_ready) begin
      if (skid_v_q) begin
        in_valid_q <= 1'b1;
        in_data_q  <= skid_q;
        in_last_q  <= skid_last_q;
        skid_v_q   <= 1'b0;
      end else begin
        in_valid_q <= push;
        in_data_q  <= resp_byte;
        in_last_q  <= push_last;
      end
    end else if (push) begin
      skid_v_q    <= 1'b1;
      skid_q      <= resp_byte;
      skid_last_q <= push_last;
    end
  end

  // Request intake, I2C sequencing and answer emission
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_q        <= S_RECV;
      out_ready_q <= 1'b1;
      len_ok_q    <= 1'b0;
      rx_idx_q    <= 6'd0;
      resp_idx_q  <= 6'd0;
      id_q        <= 8'h00;
      flags_q     <= 8'h00;
      wcnt_q      <= 8'h00;
      rcnt_q      <= 8'h00;
      addr_q      <= 8'h00;
      widx_q      <= 6'd0;
      ridx_q      <= 6'd0;
      wdone_q     <= 6'd0;
      addr_pend_q <= 1'b0;
      rd_phase_q  <= 1'b0;
      rd_byte_q   <= 1'b0;
      is_addr_q   <= 1'b0;
      tx_q        <= 9'h1ff;
      rx_sh_q     <= 8'h00;
      bit_q       <= 4'd0;
      tmr_q       <= 16'h0000;
      wd_q        <= 32'd0;
      rerr_q      <= 1'b0;
      nack_q      <= 1'b0;
      arb_q       <= 1'b0;
      tmo_q       <= 1'b0;
      scl_oe_q    <= 1'b0;
      sda_oe_q    <= 1'b0;
    end else begin
      case (st_q)
        S_RECV: begin
          if (out_valid && out_ready_q) begin
            case (rx_idx_q)
              6'd0:               id_q    <= out_data;
              6'(`OFS_FLAGS):     flags_q <= out_data;
              6'(`OFS_WCNT):      wcnt_q  <= out_data;
              6'(`OFS_RCNT):      rcnt_q  <= out_data;
              6'(`OFS_ADDR):      addr_q  <= out_data;
              default: begin
                if (rx_idx_q < 6'(`OUT_REPORT_LEN))
                  wbuf_q[5'(rx_idx_q - 6'(`OFS_DATA))] <= out_data;
              end
            endcase
            if (rx_idx_q != 6'h3f) rx_idx_q <= rx_idx_q + 6'd1;
            if (out_last) begin
              out_ready_q <= 1'b0;
              len_ok_q    <= rx_idx_q == 6'(`OUT_REPORT_LEN - 1);
              st_q        <= S_CHECK;
            end
          end
        end
        S_CHECK: begin
          rerr_q      <= bad_req;
          nack_q      <= 1'b0;
          arb_q       <= 1'b0;
          tmo_q       <= 1'b0;
          widx_q      <= 6'd0;
          ridx_q      <= 6'd0;
          wdone_q     <= 6'd0;
          wd_q        <= 32'd0;
          resp_idx_q  <= 6'd0;
          addr_pend_q <= flags_q[`FLG_START];
          rd_phase_q  <= wcnt_q == 8'h00 && rcnt_q != 8'h00;
          if (bad_req) st_q <= S_RESP;
          else if (flags_q[`FLG_START]) st_q <= S_BUSWAIT;
          else st_q <= S_NEXT;
        end
        S_BUSWAIT: begin
          wd_q <= wd_q + 32'd1;
          if (scl_s_q && sda_s_q) begin
            sda_oe_q <= 1'b1;
            tmr_q    <= scl_high_q;
            st_q     <= S_START;
          end else if (wd_q >= 32'(BUS_FREE_CYC)) begin
            tmo_q <= 1'b1;
            st_q  <= S_RESP;
          end
        end
        S_START: begin
          tmr_q <= tmr_q - 16'd1;
          if (tmr_done) begin
            scl_oe_q <= 1'b1;
            st_q     <= S_NEXT;
          end
        end
        S_NEXT: begin
          wd_q  <= 32'd0;
          bit_q <= 4'd0;
          tmr_q <= scl_low_q;
          if (addr_pend_q) begin
            addr_pend_q <= 1'b0;
            is_addr_q   <= 1'b1;
            rd_byte_q   <= 1'b0;
            tx_q        <= {addr_q[7:1], rd_phase_q, 1'b1};
            sda_oe_q    <= !addr_q[7];
            st_q        <= S_BIT_LO;
          end else if (!rd_phase_q && widx_q < 6'(wcnt_q)) begin
            is_addr_q <= 1'b0;
            rd_byte_q <= 1'b0;
            tx_q      <= {wbuf_q[5'(widx_q)], 1'b1};
            sda_oe_q  <= !wbuf_q[5'(widx_q)][7];
            widx_q    <= widx_q + 6'd1;
            st_q      <= S_BIT_LO;
          end else if (!rd_phase_q && rcnt_q != 8'h00) begin
            rd_phase_q  <= 1'b1;
            addr_pend_q <= 1'b1;
            sda_oe_q    <= 1'b0;
            st_q        <= S_RS_LO;
          end else if (rd_phase_q && ridx_q < 6'(rcnt_q)) begin
            is_addr_q <= 1'b0;
            rd_byte_q <= 1'b1;
            sda_oe_q  <= 1'b0;
            // Last byte NAKed unless the host extends the read
            tx_q <= {8'hff, ridx_q == 6'(rcnt_q - 8'd1) &&
                            !flags_q[`FLG_ACK_LAST]};
            st_q <= S_BIT_LO;
          end else if (flags_q[`FLG_STOP]) begin
            sda_oe_q <= 1'b1;
            st_q     <= S_SP_LO;
          end else begin
            st_q <= S_RESP;
          end
        end
        S_BIT_LO: begin
          wd_q  <= wd_q + 32'd1;
          tmr_q <= tmr_q - 16'd1;
          if (tmr_done) begin
            scl_oe_q <= 1'b0;
            tmr_q    <= scl_high_q;
            st_q     <= S_BIT_HI;
          end
        end
        S_BIT_HI: begin
          wd_q <= wd_q + 32'd1;
          if (wd_q >= 32'(BYTE_CYC)) begin
            tmo_q    <= 1'b1;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            st_q     <= S_RESP;
          end else if (scl_s_q) begin
            // Counts only while the slave is not stretching the clock
            tmr_q <= tmr_q - 16'd1;
            if (tmr_done) begin
              scl_oe_q <= 1'b1;
              tmr_q    <= scl_low_q;
              if (tx_q[8] && !sda_s_q && (rd_byte_q == (bit_q == 4'd8))) begin
                arb_q    <= 1'b1;
                scl_oe_q <= 1'b0;
                sda_oe_q <= 1'b0;
                st_q     <= S_RESP;
              end else if (bit_q == 4'd8 && !rd_byte_q && sda_s_q) begin
                nack_q   <= 1'b1;
                sda_oe_q <= 1'b1;
                st_q     <= S_SP_LO;
              end else if (bit_q == 4'd8) begin
                if (rd_byte_q) begin
                  rbuf_q[5'(ridx_q)] <= rx_sh_q;
                  ridx_q             <= ridx_q + 6'd1;
                end else if (!is_addr_q) begin
                  wdone_q <= wdone_q + 6'd1;
                end
                st_q <= S_NEXT;
              end else begin
                rx_sh_q  <= {rx_sh_q[6:0], sda_s_q};
                tx_q     <= {tx_q[7:0], 1'b1};
                sda_oe_q <= !tx_q[7];
                bit_q    <= bit_q + 4'd1;
                st_q     <= S_BIT_LO;
              end
            end
          end
        end
        S_RS_LO: begin
          tmr_q <= tmr_q - 16'd1;
          if (tmr_done) begin
            scl_oe_q <= 1'b0;
            tmr_q    <= scl_high_q;
            st_q     <= S_RS_HI;
          end
        end
        S_RS_HI: begin
          if (scl_s_q) begin
            tmr_q <= tmr_q - 16'd1;
            if (tmr_done) begin
              sda_oe_q <= 1'b1;
              tmr_q    <= scl_high_q;
              st_q     <= S_START;
            end
          end
        end
        S_SP_LO: begin
          tmr_q <= tmr_q - 16'd1;
          if (tmr_done) begin
            scl_oe_q <= 1'b0;
            tmr_q    <= scl_high_q;
            st_q     <= S_SP_HI;
          end
        end
        S_SP_HI: begin
          if (scl_s_q) begin
            tmr_q <= tmr_q - 16'd1;
            if (tmr_done) begin
              sda_oe_q <= 1'b0;
              tmr_q    <= scl_high_q;
              st_q     <= S_SP_END;
            end
          end
        end
        S_SP_END: begin
          tmr_q <= tmr_q - 16'd1;
          if (tmr_done) st_q <= S_RESP;
        end
        S_RESP: begin
          if (push) begin
            resp_idx_q <= resp_idx_q + 6'd1;
            if (push_last) begin
              rx_idx_q    <= 6'd0;
              out_ready_q <= 1'b1;
              st_q        <= S_RECV;
            end
          end
        end
        default: st_q <= S_RECV;
      endcase
    end
  end

  assign out_ready   = out_ready_q;
  assign in_valid    = in_valid_q;
  assign in_data     = in_data_q;
  assign in_last     = in_last_q;
  assign feat_rdata  = feat_rdata_q;
  assign feat_rvalid = feat_rvalid_q;
  assign scl_out     = low_q;
  assign sda_out     = low_q;
  assign scl_oe      = scl_oe_q;
  assign sda_oe      = sda_oe_q;

endmodule

// ---- shared/hid_i2c_cfg.svh ----
// Offsets, field positions, reset values and timing of the HID I2C bridge
`ifndef HID_I2C_CFG_SVH
`define HID_I2C_CFG_SVH
`define CLK_HZ          10000000
`define BUS_FREE_MS     256
`define BYTE_MS         10
`define OUT_REPORT_LEN  37
`define IN_REPORT_LEN   36
`define OUT_REPORT_ID   8'h00
`define MAX_XFER        32
`define OFS_FLAGS       1
`define OFS_WCNT        2
`define OFS_RCNT        3
`define OFS_ADDR        4
`define OFS_DATA        5
`define IN_OFS_DATA     4
`define FLG_START       0
`define FLG_STOP        1
`define FLG_ACK_LAST    2
`define FEAT_REG_WRITE  8'h3c
`define FEAT_READ_PTR   8'h4b
`define FEAT_READBACK   8'h5a
`define REG_STATUS      16'h0340
`define REG_SCL_LOW     16'h0341
`define REG_SCL_HIGH    16'h0342
`define SCL_LOW_RST     16'h0032
`define SCL_HIGH_RST    16'h0032
`endif

// ---- shared/hid_i2c_pkg.sv ----
// Types shared by the HID I2C bridge
package hid_i2c_pkg;
  typedef enum logic [3:0] {
    S_RECV    = 4'h0,
    S_CHECK   = 4'h1,
    S_BUSWAIT = 4'h2,
    S_START   = 4'h3,
    S_NEXT    = 4'h4,
    S_BIT_LO  = 4'h5,
    S_BIT_HI  = 4'h6,
    S_RS_LO   = 4'h7,
    S_RS_HI   = 4'h8,
    S_SP_LO   = 4'h9,
    S_SP_HI   = 4'ha,
    S_SP_END  = 4'hb,
    S_RESP    = 4'hc
  } xfer_state_t;
endpackage

// ---- verification/hid_i2c_bridge_assertions.sv ----
// Port assertions for the HID report I2C bridge
`timescale 1ns/1ps
module hid_i2c_bridge_assertions #(
  parameter int BUS_FREE_CYC = 2560000,
  parameter int BYTE_CYC     = 100000
) (
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic        out_valid,
  input wire logic        out_last,
  input wire logic        out_ready,
  input wire logic        in_valid,
  input wire logic [7:0]  in_data,
  input wire logic        in_last,
  input wire logic        in_ready,
  input wire logic        feat_valid,
  input wire logic [7:0]  feat_id,
  input wire logic [15:0] feat_rdata,
  input wire logic        feat_rvalid,
  input wire logic        scl_oe,
  input wire logic        sda_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic [5:0] beat_q;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn)
      beat_q <= 6'h00;
    else if (in_valid && in_ready)
      beat_q <= in_last ? 6'h00 : beat_q + 6'h01;
  end
  a_ready_drop: assert property (
    out_valid && out_ready && out_last |=> !out_ready)
    else $error("ready still high after report end");
  a_answer_hold: assert property (
    in_valid && !in_ready |=> in_valid && $stable(in_data) && $stable(in_last))
    else $error("answer byte lost during stall");
  a_readback_pulse: assert property (
    feat_valid && feat_id == 8'h5a |=> feat_rvalid)
    else $error("no readback pulse");
  a_readback_cause: assert property (
    feat_rvalid |-> $past(feat_valid) && $past(feat_id) == 8'h5a)
    else $error("readback pulse without request");
  a_answer_length: assert property (
    in_valid && in_last |-> beat_q == 6'd35)
    else $error("answer length wrong");
  a_rdata_hold: assert property (
    !feat_rvalid |-> $stable(feat_rdata))
    else $error("readback value moved");
  a_no_unasked: assert property (
    out_ready && !in_valid && !(out_valid && out_last) |=> !in_valid)
    else $error("answer without request");
  a_bus_on_request: assert property (
    $rose(scl_oe) || $rose(sda_oe) |-> !out_ready)
    else $error("bus driven without request");
  c_answer: cover property (in_valid && in_ready && in_last);
  c_stall: cover property (in_valid && !in_ready);
  c_readback: cover property (feat_rvalid);
endmodule

bind hid_report_i2c_master_transfer hid_i2c_bridge_assertions #(
  .BUS_FREE_CYC(BUS_FREE_CYC), .BYTE_CYC(BYTE_CYC)) chk_i (
  .sys_clk(sys_clk), .resetn(resetn), .out_valid(out_valid),
  .out_last(out_last), .out_ready(out_ready), .in_valid(in_valid),
  .in_data(in_data), .in_last(in_last), .in_ready(in_ready),
  .feat_valid(feat_valid), .feat_id(feat_id), .feat_rdata(feat_rdata),
  .feat_rvalid(feat_rvalid), .scl_oe(scl_oe), .sda_oe(sda_oe));

// ---- verification/hid_report_i2c_master_transfer_bench.sv ----
// Self-checking bench for the HID report I2C bridge
`timescale 1ns/1ps
module hid_report_i2c_master_transfer_bench;
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        out_valid = 1'b0;
  logic        out_last = 1'b0;
  logic        in_ready = 1'b0;
  logic        feat_valid = 1'b0;
  logic        jam = 1'b0;
  logic [7:0]  out_data = 8'h00;
  logic [7:0]  feat_id = 8'h00;
  logic [15:0] feat_addr = 16'h0000;
  logic [15:0] feat_wdata = 16'h0000;
  logic [15:0] feat_rdata;
  logic        out_ready, in_valid, in_last, feat_rvalid, pull;
  logic        scl_out, scl_oe, sda_out, sda_oe, scl_w, sda_w;
  logic [7:0]  in_data;
  logic [7:0]  req [37];
  logic [7:0]  ans [36];
  logic [7:0]  wc [4] = '{8'h21, 8'h01, 8'h01, 8'h01};
  logic [7:0]  rc [4] = '{8'h00, 8'h21, 8'h00, 8'h00};
  int          fails = 0;
  int          cmp_count = 0;
  int          cyc = 0;

  always #50 sys_clk = ~sys_clk;
  // Open-drain wires with pull-ups
  assign scl_w = scl_oe ? scl_out : 1'b1;
  // Jam holds SDA low so the bus never looks free
  assign sda_w = (sda_oe ? sda_out : 1'b1) & ~pull & ~jam;

  hid_report_i2c_master_transfer #(.BUS_FREE_CYC(200), .BYTE_CYC(400)) uut (
    .sys_clk(sys_clk), .resetn(resetn), .out_valid(out_valid),
    .out_data(out_data), .out_last(out_last), .out_ready(out_ready),
    .in_valid(in_valid), .in_data(in_data), .in_last(in_last),
    .in_ready(in_ready), .feat_valid(feat_valid), .feat_id(feat_id),
    .feat_addr(feat_addr), .feat_wdata(feat_wdata),
    .feat_rdata(feat_rdata), .feat_rvalid(feat_rvalid), .scl_in(scl_w),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe));
  i2c_slave_model slv (.scl(scl_w), .sda(sda_w), .sda_pull(pull));

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic feat(input logic [7:0] id, input logic [15:0] a,
                      input logic [15:0] d);
    @(negedge sys_clk);
    feat_valid = 1'b1;
    feat_id = id;
    feat_addr = a;
    feat_wdata = d;
    @(negedge sys_clk);
    feat_valid = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    feat(8'h4b, a, 16'h0000);
    feat(8'h5a, 16'h0000, 16'h0000);
    chk(8'(feat_rvalid), 8'h01);
    chk(feat_rdata[7:0], e[7:0]);
    chk(feat_rdata[15:8], e[15:8]);
  endtask

  // First n request bytes out, then the whole answer back with optional stalls
  task automatic xfer(input logic [7:0] id, input logic [7:0] f,
                      input logic [7:0] w, input logic [7:0] r,
                      input logic [7:0] a, input int n, input int stall);
    req[0] = id;
    req[1] = f;
    req[2] = w;
    req[3] = r;
    req[4] = a;
    for (int i = 5; i < 37; i++)
      req[i] = 8'h0b + i[7:0];
    slv.log.delete();
    slv.starts = 0;
    slv.stops = 0;
    for (int i = 0; i < n; i++) begin
      @(negedge sys_clk);
      out_valid = 1'b1;
      out_data = req[i];
      out_last = (i == n - 1);
      while (!out_ready) @(negedge sys_clk);
    end
    @(negedge sys_clk);
    out_valid = 1'b0;
    out_last = 1'b0;
    for (int i = 0; i < 36; i++) begin
      if (stall > 0) begin
        in_ready = 1'b0;
        repeat (stall) @(negedge sys_clk);
      end
      in_ready = 1'b1;
      while (!in_valid) @(negedge sys_clk);
      ans[i] = in_data;
      if (i == 35)
        chk(8'(in_last), 8'h01);
      @(negedge sys_clk);
    end
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      complete_run();
    end
  end

  initial begin
    repeat (3) @(negedge sys_clk);
    chk(8'(out_ready), 8'h01);
    chk({6'h00, scl_oe, sda_oe}, 8'h00);
    resetn = 1'b1;
    rd(16'h0341, 16'h0032);
    feat(8'h3c, 16'h0341, 16'h0004);
    feat(8'h3c, 16'h0342, 16'h0004);
    rd(16'h0342, 16'h0004);
    rd(16'h0100, 16'h0000);
    $display("test registers done");
    xfer(8'h00, 8'h53, 8'h02, 8'h00, 8'h55, 37, 0);
    chk(ans[0], 8'h50);
    chk(ans[1], 8'h02);
    chk(ans[2], 8'h00);
    chk(8'(slv.log.size()), 8'h03);
    chk(slv.log[0], 8'h54);
    chk(slv.log[2], 8'h11);
    chk(8'(slv.starts), 8'h01);
    chk(8'(slv.stops), 8'h01);
    $display("test write done");
    xfer(8'h00, 8'h93, 8'h01, 8'h03, 8'hf2, 37, 3);
    chk(slv.log[2], 8'hf3);
    chk(8'(slv.log.size()), 8'h03);
    chk(8'(slv.starts), 8'h02);
    chk(ans[2], 8'h03);
    chk(ans[6], 8'hc2);
    chk(ans[7], 8'h00);
    chk(8'(slv.mack), 8'h00);
    $display("test ten-bit read done");
    xfer(8'h00, 8'h27, 8'h00, 8'h01, 8'h54, 37, 0);
    chk(slv.log[0], 8'h55);
    chk(ans[0], 8'h20);
    chk(ans[4], 8'hc0);
    chk(8'(slv.mack), 8'h01);
    $display("test read ack done");
    xfer(8'h00, 8'h13, 8'h01, 8'h00, 8'h66, 37, 0);
    chk(ans[0], 8'h12);
    chk(8'(slv.stops), 8'h01);
    $display("test nak done");
    jam = 1'b1;
    @(negedge sys_clk);
    xfer(8'h00, 8'h43, 8'h01, 8'h00, 8'h54, 37, 0);
    jam = 1'b0;
    chk(ans[0], 8'h48);
    chk(ans[1], 8'h00);
    chk(8'(slv.starts), 8'h00);
    @(negedge sys_clk);
    $display("test bus timeout done");
    for (int k = 0; k < 4; k++) begin
      xfer(8'(k == 2), 8'h03, wc[k], rc[k], 8'h54, 37 - int'(k == 3), 0);
      chk(ans[0], 8'h01);
      chk(ans[1], 8'h00);
      chk(8'(slv.starts), 8'h00);
    end
    $display("test refused requests done");
    complete_run();
  end
endmodule

// ---- verification/i2c_slave_model.sv ----
// Behavioural I2C target that logs received bytes and serves read data
`timescale 1ns/1ps
module i2c_slave_model #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  input  wire logic scl,
  input  wire logic sda,
  output logic      sda_pull
);
  logic [7:0] sh = 8'h00;
  logic [7:0] tx = 8'hff;
  logic [7:0] log [$];
  int         bitn = 0;
  int         starts = 0;
  int         stops = 0;
  int         rd_idx = 0;
  logic       act = 1'b0;
  logic       adr = 1'b0;
  logic       rd = 1'b0;
  logic       ok = 1'b0;
  logic       mack = 1'b0;
  initial sda_pull = 1'b0;
  // Levels rechecked a moment later: SDA may move with the SCL fall
  always @(negedge sda) begin
    #1;
    if (scl === 1'b1 && sda === 1'b0) begin
      starts++;
      act = 1'b1;
      adr = 1'b1;
      bitn = 0;
    end
  end
  always @(posedge sda) begin
    #1;
    if (scl === 1'b1 && sda === 1'b1) begin
      stops++;
      act = 1'b0;
    end
  end
  always @(posedge scl) if (act) begin
    if (bitn < 8)
      sh = {sh[6:0], sda};
    else if (adr) begin
      adr = 1'b0;
      act = ok;
    end else if (rd)
      mack = !sda;
    if (bitn == 7 && adr) begin
      rd = sh[0];
      rd_idx = 0;
      // Ten-bit prefix accepted for any upper bits
      ok = sh[7:1] == ADDR || sh[7:3] == 5'b11110;
    end
    if (bitn == 7 && (adr || !rd))
      log.push_back(sh);
    bitn = (bitn == 8) ? 0 : bitn + 1;
  end
  // Read bytes start with a one so a stop is never blocked
  always @(negedge scl) if (act) begin
    if (bitn == 8)
      sda_pull = (adr || !rd) && ok;
    else if (rd && !adr) begin
      if (bitn == 0) begin
        tx = 8'hc0 + rd_idx[7:0];
        rd_idx++;
      end
      sda_pull = !tx[7 - bitn];
    end else
      sda_pull = 1'b0;
  end
endmodule
